/* File: inc/acmpc_pkg.sv */
// package for the converter control block: register map, fields, resets, timing
// Notes on behaviour
// - any write to status/control one aborts; it restarts unless channel is all ones.
// - up to 28 analog inputs, chosen by the channel select field.
// - compare high holds upper two bits, compared in 10-bit mode when enabled.
// - in 8-bit mode the compare high register is ignored.
// - compare low eight bits compared against low eight result bits, both modes.
// - configuration holds mode, clock source, divide, low power and long sample.
package acmpc_pkg;
    localparam int ADDR_W = 4;
    // word offsets on the bus, index times four
    localparam logic [ADDR_W-1:0] OFS_SC1 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SC2 = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_RESH = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_RESL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CVH = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CVL = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CFG = 4'h6;
    // status/control one fields
    localparam int SC1_COCO = 7;
    localparam int SC1_CONT = 5;
    localparam logic [4:0] CH_OFF = 5'h1F;
    localparam int NUM_CH = 28;
    // status/control two fields
    localparam int SC2_ACT = 7;
    localparam int SC2_CMPGT = 4;
    localparam int SC2_CMPEN = 5;
    // configuration fields
    localparam int CFG_LP = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LSMP = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    // reset values
    localparam logic [7:0] SC1_RST = 8'h1F;
    localparam logic [7:0] SC2_RST = 8'h00;
    localparam logic [7:0] CV_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    // conversion timing in converter clocks
    localparam logic [5:0] SAMPLE_SHORT = 6'h04;
    localparam logic [5:0] SAMPLE_LONG = 6'h18;
    localparam logic [5:0] BITS_10 = 6'h0A;
    localparam logic [5:0] BITS_8 = 6'h08;
    localparam logic [5:0] LP_EXTRA = 6'h04;
endpackage

/* File: rtl/acmpc_clkdiv.sv */
// converter clock tick generator: divide ratio 1,2,4,8 from the bus clock
module acmpc_clkdiv (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic run,
    input wire logic [1:0] div_sel,
    output logic tick
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } acmpc_div_t;
    acmpc_div_t s_q, s_d;
    logic [2:0] lim;

    // limit is ratio minus one; counter only runs during a conversion
    always_comb begin
        lim = 3'((4'h1 << div_sel) - 4'h1);
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 3'h0;
        end else if (s_q.cnt >= lim) begin
            s_d.cnt = 3'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule

/* File: rtl/acmpc_ctrl.sv */
// converter control: start/abort, channel select, compare, classic wishbone slave
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
module acmpc_ctrl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [9:0] sar_bit_i,
    output logic [4:0] channel_select,
    output logic sample_en,
    output logic [3:0] sar_step,
    output logic conv_done
);
    import acmpc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV = 3'b100
    } acmpc_st_t;

    typedef struct packed {
        acmpc_st_t st;
        logic [7:0] sc1;
        logic [7:0] sc2;
        logic [7:0] cvh;
        logic [7:0] cvl;
        logic [7:0] cfg;
        logic [9:0] result;
        logic [9:0] sar;
        logic [5:0] cnt;
        logic [31:0] dat;
        logic ack;
        logic sample;
        logic done;
        logic [4:0] chs;
    } acmpc_state_t;

    acmpc_state_t s_q, s_d;
    logic tick;
    logic bus_req;
    logic wr0;

    // true when the compare condition holds for a finished result
    function automatic logic cmp_hit(input logic [9:0] res, input logic [7:0] cvh,
                                     input logic [7:0] cvl, input logic ten,
                                     input logic gt);
        logic [9:0] ref_v;
        logic [9:0] r;
        ref_v = ten ? {cvh[1:0], cvl} : {2'h0, cvl};
        r = ten ? res : {2'h0, res[7:0]};
        cmp_hit = gt ? (r >= ref_v) : (r < ref_v);
    endfunction

    // ten-bit mode decode, shared by the sequencer and the compare
    function automatic logic ten_mode(input logic [7:0] cfg);
        ten_mode = (cfg[CFG_MODE_LSB +: 2] == MODE_10BIT);
    endfunction

    // channels above the implemented range fall back to the first input
    function automatic logic [4:0] ch_clamp(input logic [4:0] ch);
        ch_clamp = (ch < 5'(NUM_CH)) ? ch : 5'h00;
    endfunction

    // bits the successive approximation needs for the current mode
    function automatic logic [5:0] conv_bits(input logic [7:0] cfg);
        conv_bits = ten_mode(cfg) ? BITS_10 : BITS_8;
    endfunction

    // sample time; long sample and low power each stretch it
    function automatic logic [5:0] samp_len(input logic [7:0] cfg);
        logic [5:0] b;
        b = cfg[CFG_LSMP] ? SAMPLE_LONG : SAMPLE_SHORT;
        samp_len = cfg[CFG_LP] ? 6'(b + LP_EXTRA) : b;
    endfunction

    acmpc_clkdiv u_div (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .run(s_q.st != ST_IDLE),
        .div_sel(s_q.cfg[CFG_DIV_LSB +: 2]),
        .tick(tick)
    );

    // a request is taken once; the ack flop blocks a second take
    assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign wr0 = bus_req && wb_we_i && wb_sel_i[0];

    always_comb begin
        logic [9:0] res;
        logic ten;
        logic [3:0] idx;
        res = '0;
        ten = 1'b0;
        idx = '0;
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.done = 1'b0;
        s_d.sample = 1'b0;

        // sequencer: sample, then one approximation bit per converter tick
        case (s_q.st)
            ST_IDLE: begin
                s_d.cnt = 6'h00;
            end
            ST_SAMPLE: begin
                s_d.sample = 1'b1;
                if (tick) begin
                    if (s_q.cnt + 6'h01 >= samp_len(s_q.cfg)) begin
                        s_d.st = ST_CONV;
                        s_d.cnt = 6'h00;
                        s_d.sample = 1'b0;
                    end else begin
                        s_d.cnt = s_q.cnt + 6'h01;
                    end
                end
            end
            ST_CONV: begin
                if (tick) begin
                    idx = 4'(conv_bits(s_q.cfg) - 6'h01 - s_q.cnt);
                    s_d.sar[idx] = sar_bit_i[idx];
                    if (s_q.cnt + 6'h01 >= conv_bits(s_q.cfg)) begin
                        ten = ten_mode(s_q.cfg);
                        res = s_d.sar;
                        // compare gates storage only when enabled
                        if (!s_q.sc2[SC2_CMPEN] ||
                            cmp_hit(res, s_q.cvh, s_q.cvl, ten, s_q.sc2[SC2_CMPGT])) begin
                            s_d.result = res;
                            s_d.sc1[SC1_COCO] = 1'b1;
                            s_d.done = 1'b1;
                        end
                        if (s_q.sc1[SC1_CONT]) begin
                            s_d.st = ST_SAMPLE;
                        end else begin
                            s_d.st = ST_IDLE;
                        end
                        s_d.cnt = 6'h00;
                        s_d.sar = 10'h000;
                    end else begin
                        s_d.cnt = s_q.cnt + 6'h01;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // bus writes; a status/control one write restarts the sequence, or aborts it when the channel is all ones
        if (bus_req) begin
            s_d.ack = 1'b1;
            if (wr0) begin
                case (wb_adr_i)
                    OFS_SC1: begin
                        s_d.sc1 = {1'b0, wb_dat_i[6:0]};
                        s_d.sar = 10'h000;
                        s_d.cnt = 6'h00;
                        if (wb_dat_i[4:0] == CH_OFF) begin
                            s_d.st = ST_IDLE;
                        end else begin
                            s_d.st = ST_SAMPLE;
                        end
                    end
                    OFS_SC2: s_d.sc2[6:4] = wb_dat_i[6:4];
                    OFS_CVH: s_d.cvh = {6'h00, wb_dat_i[1:0]};
                    OFS_CVL: s_d.cvl = wb_dat_i[7:0];
                    OFS_CFG: s_d.cfg = wb_dat_i[7:0];
                    default: ;
                endcase
            end
            // reads of result low clear the completion flag
            case (wb_adr_i)
                OFS_SC1: s_d.dat = {24'h0, s_q.sc1};
                OFS_SC2: s_d.dat = {24'h0, s_q.sc2[7:1], 1'b0};
                OFS_RESH: s_d.dat = {30'h0, s_q.result[9:8]};
                OFS_RESL: s_d.dat = {24'h0, s_q.result[7:0]};
                OFS_CVH: s_d.dat = {24'h0, s_q.cvh};
                OFS_CVL: s_d.dat = {24'h0, s_q.cvl};
                OFS_CFG: s_d.dat = {24'h0, s_q.cfg};
                default: s_d.dat = 32'h0;
            endcase
            if (!wb_we_i && wb_adr_i == OFS_RESL && !s_d.done) begin
                s_d.sc1[SC1_COCO] = 1'b0; // a completion in the same cycle wins
            end
        end
        // busy flag follows the next state so software sees it at once
        s_d.sc2[SC2_ACT] = (s_d.st != ST_IDLE);
        // channel output registered so the port comes from a flop
        s_d.chs = ch_clamp(s_d.sc1[4:0]);
    end

    // reset beats the clock enable so a frozen block still resets
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.sc1 <= SC1_RST;
            s_q.sc2 <= SC2_RST;
            s_q.cvh <= CV_RST;
            s_q.cvl <= CV_RST;
            s_q.cfg <= CFG_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // every output comes straight from a flop
    assign channel_select = s_q.chs;
    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign sample_en = s_q.sample;
    assign sar_step = s_q.cnt[3:0];
    assign conv_done = s_q.done;
endmodule

/* File: testbench/acmpc_ctrl_sva.sv */
// checker for the converter control block ports
module acmpc_ctrl_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [9:0] sar_bit_i,
    input wire logic [4:0] channel_select,
    input wire logic sample_en,
    input wire logic [3:0] sar_step,
    input wire logic conv_done
);
    import acmpc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // a request taken, and a write of status/control one
    sequence s_take;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_sc1_wr;
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_SC1);
    endsequence
    AST_START: assert property (s_sc1_wr ##0 (wb_dat_i[4:0] != CH_OFF)
        |-> ##[1:3] sample_en) else $error("conversion did not start");
    AST_OFF: assert property (s_sc1_wr ##0 (wb_dat_i[4:0] == CH_OFF)
        |-> ##3 (!sample_en && !conv_done)[*4]) else $error("off did not abort");
    AST_CH: assert property ((channel_select < 5'h1C) || (channel_select == CH_OFF))
        else $error("channel out of range");
    AST_ACK: assert property (s_take |=> wb_ack_o) else $error("no ack");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_UNMAP: assert property (s_take ##0 (!wb_we_i && wb_adr_i > OFS_CFG)
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    AST_DONE: assert property (conv_done |=> !conv_done) else $error("done held");
    // a low clock enable holds the sequencer, ack and channel outputs
    AST_FREEZE: assert property (!ce |=> $stable(sample_en) && $stable(sar_step)
        && $stable(conv_done) && $stable(wb_ack_o) && $stable(channel_select))
        else $error("state moved with clock enable low");
endmodule

bind acmpc_ctrl acmpc_ctrl_sva i_acmpc_ctrl_sva (.clk, .rstn, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sar_bit_i,
    .channel_select, .sample_en, .sar_step, .conv_done);

/* File: testbench/tb.sv */
// self-checking bench for the converter control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import acmpc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [9:0] sar = 10'h000;
    logic [31:0] rdat;
    logic ack, done, smp;
    logic [4:0] chs;
    logic [3:0] stp;
    logic [7:0] v;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    acmpc_ctrl i_acmpc_ctrl (.clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sar_bit_i(sar), .channel_select(chs), .sample_en(smp),
        .sar_step(stp), .conv_done(done));
    // one classic cycle; read data is taken at the ack edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        v = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(v, exp);
    endtask
    // start, poll the complete flag for a bounded time, compare it
    task automatic conv(input logic [7:0] c, input logic exp, input int hold = 0);
        bus(1'b1, OFS_SC1, c);
        // optional freeze in mid-sample; the run must resume where it stood
        if (hold > 0) begin
            ce <= 1'b0;
            repeat (hold) @(posedge clk);
            chk({7'h0, smp}, 8'h01);
            ce <= 1'b1;
        end
        for (int i = 0; i < 40; i++) begin
            bus(1'b0, OFS_SC1, 8'h00);
            if (v[7]) break;
        end
        chk({7'h0, v[7]}, {7'h0, exp});
    endtask
    task automatic report_and_stop;
        $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rdchk(OFS_SC1, SC1_RST);
        rdchk(OFS_SC2, SC2_RST);
        rdchk(OFS_CVH, CV_RST);
        rdchk(OFS_CVL, CV_RST);
        rdchk(OFS_CFG, CFG_RST);
        bus(1'b1, 4'h7, 8'hFF);
        rdchk(4'h7, 8'h00);
        bus(1'b1, OFS_CFG, 8'hF9);
        rdchk(OFS_CFG, 8'hF9);
        bus(1'b1, OFS_CVH, 8'h03);
        rdchk(OFS_CVH, 8'h03);
        // 10-bit, compare off: every completion flagged
        bus(1'b1, OFS_CFG, 8'h08);
        sar <= 10'h2A5;
        conv(8'h03, 1'b1);
        chk({3'h0, chs}, 8'h03);
        chk({4'h0, stp}, 8'h00);
        rdchk(OFS_RESH, 8'h02);
        rdchk(OFS_RESL, 8'hA5);
        rdchk(OFS_SC1, 8'h03);
        // greater-or-equal compare: high bits, then low bits decide
        bus(1'b1, OFS_SC2, 8'h30);
        conv(8'h04, 1'b0);
        bus(1'b1, OFS_CVH, 8'h02);
        bus(1'b1, OFS_CVL, 8'hA5);
        conv(8'h04, 1'b1);
        rdchk(OFS_RESL, 8'hA5);
        bus(1'b1, OFS_CVL, 8'hA6);
        conv(8'h04, 1'b0);
        // 8-bit: high compare register must not count
        bus(1'b1, OFS_CFG, 8'h00);
        bus(1'b1, OFS_CVH, 8'h03);
        bus(1'b1, OFS_CVL, 8'hFF);
        sar <= 10'h3FF;
        conv(8'h05, 1'b1);
        rdchk(OFS_RESL, 8'hFF);
        conv(8'h07, 1'b1, 8);
        // abort straight after a start
        bus(1'b1, OFS_SC2, 8'h00);
        bus(1'b1, OFS_SC1, 8'h06);
        conv({3'h0, CH_OFF}, 1'b0);
        bus(1'b1, OFS_SC1, 8'h1D);
        chk({3'h0, chs}, 8'h00);
        bus(1'b1, OFS_SC1, 8'h1F);
        report_and_stop;
    end
endmodule
